// ==== include/apd_pkg.sv ====
package apd_pkg;

  // Configuration register indices
  localparam logic [7:0] APD_IDX_GLOBAL_STANDBY_COUNT = 8'h39;
  localparam logic [7:0] APD_IDX_POWER_TIMER_SMI_CTRL = 8'h3a;
  localparam logic [7:0] APD_IDX_TEST_RESERVED        = 8'h3b;
  localparam logic [7:0] APD_IDX_FUNCTION_IDLE_STATUS = 8'h40;
  localparam logic [7:0] APD_IDX_FUNCTION_WAKE_STATUS = 8'h41;
  localparam logic [7:0] APD_IDX_FUNCTION_IRQ_STATUS  = 8'h42;
  localparam logic [7:0] APD_IDX_RESERVED_A           = 8'h43;
  localparam logic [7:0] APD_IDX_RESERVED_B           = 8'h44;
  localparam logic [7:0] APD_IDX_SMI_SOURCE_ENABLE    = 8'h45;

  // Reset values
  localparam logic [7:0] APD_RST_BYTE  = 8'h00;
  localparam logic [3:0] APD_RST_NIB   = 4'h0;

  // Control register field positions
  localparam int APD_BIT_TIMER_RES_SEL   = 5;
  localparam int APD_BIT_SMI_OUT_EN      = 2;
  localparam int APD_BIT_SIRQ_PULLUP_EN  = 0;

  // Function slots in the four-bit fields
  localparam int APD_FN_PRINTER = 3;
  localparam int APD_FN_FLOPPY  = 2;
  localparam int APD_FN_UART_A  = 1;
  localparam int APD_FN_UART_B  = 0;
  localparam int APD_NUM_FN     = 4;

  // Timing
  localparam longint APD_CLK_FREQ_HZ   = 64'd25_000_000;
  localparam longint APD_TICK_SEC      = 64'd1;
  localparam int     APD_SEC_CYCLES    = int'(APD_CLK_FREQ_HZ * APD_TICK_SEC);
  localparam logic [5:0] APD_SECS_PER_MIN = 6'h3c;

  // Chip-level standby machine
  typedef enum logic [1:0] {
    APD_CHIP_WORK  = 2'b00,
    APD_CHIP_COUNT = 2'b01,
    APD_CHIP_SLEEP = 2'b10
  } apd_chip_state_t;

endpackage : apd_pkg

// ==== rtl/apd_tick_gen.sv ====
`timescale 1ns/1ps
module apd_tick_gen import apd_pkg::*; #(
  parameter int SEC_CYCLES = APD_SEC_CYCLES
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_res_minute,
  output logic      o_tick
);

  logic [31:0] pre_count;
  logic [5:0]  sec_count;
  logic        sec_pulse;

  // Seconds prescaler
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pre_count <= 32'h0000_0000;
      sec_pulse <= 1'b0;
    end else if (pre_count >= 32'(SEC_CYCLES - 1)) begin
      pre_count <= 32'h0000_0000;
      sec_pulse <= 1'b1;
    end else begin
      pre_count <= pre_count + 32'h0000_0001;
      sec_pulse <= 1'b0;
    end
  end

  // Minute counter and resolution select
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sec_count <= 6'h00;
      o_tick    <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (sec_pulse) begin
        if (sec_count >= APD_SECS_PER_MIN - 6'h01) begin
          sec_count <= 6'h00;
          o_tick    <= 1'b1;
        end else begin
          sec_count <= sec_count + 6'h01;
          o_tick    <= ~i_res_minute;
        end
      end
    end
  end

endmodule : apd_tick_gen

// ==== rtl/apd_func_pm.sv ====
`timescale 1ns/1ps
module apd_func_pm import apd_pkg::*; (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_tick,
  input  wire logic       i_pm_active,
  input  wire logic       i_wake,
  input  wire logic       i_idle,
  input  wire logic [7:0] i_init_count,
  output logic            o_sleep,
  output logic            o_expire,
  output logic            o_woke
);

  logic [7:0] count;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      count    <= APD_RST_BYTE;
      o_sleep  <= 1'b0;
      o_expire <= 1'b0;
      o_woke   <= 1'b0;
    end else begin
      o_expire <= 1'b0;
      o_woke   <= 1'b0;
      if (!i_pm_active) begin
        count   <= i_init_count;
        o_sleep <= 1'b0;
      end else if (i_wake || !i_idle) begin
        count <= i_init_count;
        if (o_sleep && i_wake) begin
          o_sleep <= 1'b0;
          o_woke  <= 1'b1;
        end
      end else if (i_tick && !o_sleep && i_init_count != APD_RST_BYTE) begin
        if (count <= 8'h01) begin
          count    <= APD_RST_BYTE;
          o_sleep  <= 1'b1;
          o_expire <= 1'b1;
        end else begin
          count <= count - 8'h01;
        end
      end
    end
  end

endmodule : apd_func_pm

// ==== rtl/apd_ctrl.sv ====
// How it works
// - All functions asleep loads standby count; zero puts chip asleep.
// - Standby count of zero disables chip sleep; chip keeps current state.
// - Global standby timer runs only while chip power management is on.
// - Resolution select picks one-second or one-minute tick for all timers.
// - SMI output enable gates SMI onto the SMI pin and serial IRQ.
// - Pull-up bit enables serial IRQ pin pull-up, only in serial mode.
// - Idle flag sets on timer expiry, clears on wake; bit 3 printer.
// - Writing 1 clears idle or wake flags; writing 0 does nothing.
// - Printer idle needs no access, IRQ, DMA ack or status pin change.
// - Floppy idle needs no access, IRQ, DMA ack or motor enable set.
// - UART idle: quiet bus, receiver waiting, tx empty, modem quiet.
// - Wake sets wake flag and reloads the function's idle timer.
// - UART wakes on access, IRQ, start bit either way, modem change.
// - Printer wakes on access, IRQ, DMA ack or status pin change.
// - Floppy wakes on access, IRQ, DMA ack or motor bit set.
// - IRQ status bits mirror function IRQ levels; writes ignored.
// - SMI logic is OR of each enable ANDed with its IRQ status.
// - SMI pin asserts only with source, output and chip enables set.
// - Four SMI enable bits, printer bit 3 down to UART B bit 0.
// - Each function reloads while busy, counts down, sleeps at zero.
// - Function power management needs its own and chip enable set.
`timescale 1ns/1ps
module apd_ctrl import apd_pkg::*; #(
  parameter int SEC_CYCLES = APD_SEC_CYCLES
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_cfg_index,
  input  wire logic       i_cfg_wr,
  input  wire logic [7:0] i_cfg_wdata,
  output logic      [7:0] o_cfg_rdata,
  input  wire logic       i_chip_power_mgmt_enable,
  input  wire logic [3:0] i_func_power_mgmt_enable,
  input  wire logic [7:0] i_printer_idle_count,
  input  wire logic [7:0] i_floppy_idle_count,
  input  wire logic [7:0] i_uart_a_idle_count,
  input  wire logic [7:0] i_uart_b_idle_count,
  input  wire logic [3:0] i_func_access,
  input  wire logic [3:0] i_func_irq,
  input  wire logic       i_printer_dma_ack,
  input  wire logic       i_floppy_dma_ack,
  input  wire logic [4:0] i_printer_status_pins,
  input  wire logic [3:0] i_drive_output_register_motor,
  input  wire logic [1:0] i_uart_rx_waiting,
  input  wire logic [1:0] i_uart_tx_empty,
  input  wire logic [1:0] i_uart_rx_start,
  input  wire logic [1:0] i_uart_tx_start,
  input  wire logic [3:0] i_uart_a_modem_pins,
  input  wire logic [3:0] i_uart_b_modem_pins,
  input  wire logic       i_serial_irq_mode,
  output logic            o_smi_n,
  output logic            o_serial_irq_pin_smi,
  output logic            o_serial_irq_pullup_enable,
  output logic            o_chip_sleep,
  output logic      [3:0] o_func_sleep
);

  function automatic logic hit(input logic [7:0] idx,
                               input logic [7:0] reg_idx);
    hit = (idx == reg_idx);
  endfunction : hit

  function automatic logic [7:0] nib(input logic [3:0] v);
    nib = {4'h0, v};
  endfunction : nib

  logic [7:0]      global_standby_count;
  logic            timer_resolution_select;
  logic            smi_output_enable;
  logic            serial_irq_pullup_enable;
  logic [7:0]      test_reserved;
  logic [3:0]      function_idle_status;
  logic [3:0]      function_wake_status;
  logic [3:0]      function_irq_status;
  logic [3:0]      smi_source_enable;

  logic [4:0]      prt_pins_meta;
  logic [4:0]      prt_pins_sync;
  logic [4:0]      prt_pins_prev;
  logic [7:0]      modem_meta;
  logic [7:0]      modem_sync;
  logic [7:0]      modem_prev;
  logic [3:0]      motor_prev;

  logic            tick;
  logic [3:0]      wake_event;
  logic [3:0]      idle_cond;
  logic [3:0]      pm_active;
  logic [3:0]      fn_sleep;
  logic [3:0]      fn_expire;
  logic [3:0]      fn_woke;
  logic [7:0]      init_count [APD_NUM_FN];

  logic            prt_pin_change;
  logic [1:0]      modem_change;
  logic            motor_rise;
  logic            smi_logic;
  logic [3:0]      idle_clear;
  logic [3:0]      wake_clear;

  apd_chip_state_t chip_state;
  apd_chip_state_t next_chip_state;
  logic [7:0]      standby_count;
  logic [7:0]      next_standby_count;

  // Control register writes
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      global_standby_count     <= APD_RST_BYTE;
      timer_resolution_select  <= 1'b0;
      smi_output_enable        <= 1'b0;
      serial_irq_pullup_enable <= 1'b0;
      test_reserved            <= APD_RST_BYTE;
      smi_source_enable        <= APD_RST_NIB;
    end else if (i_cfg_wr) begin
      if (hit(i_cfg_index, APD_IDX_GLOBAL_STANDBY_COUNT)) begin
        global_standby_count <= i_cfg_wdata;
      end
      if (hit(i_cfg_index, APD_IDX_POWER_TIMER_SMI_CTRL)) begin
        timer_resolution_select  <= i_cfg_wdata[APD_BIT_TIMER_RES_SEL];
        smi_output_enable        <= i_cfg_wdata[APD_BIT_SMI_OUT_EN];
        serial_irq_pullup_enable <= i_cfg_wdata[APD_BIT_SIRQ_PULLUP_EN];
      end
      if (hit(i_cfg_index, APD_IDX_TEST_RESERVED)) begin
        test_reserved <= i_cfg_wdata;
      end
      if (hit(i_cfg_index, APD_IDX_SMI_SOURCE_ENABLE)) begin
        smi_source_enable <= i_cfg_wdata[3:0];
      end
    end
  end

  // Read path, one cycle after the index
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_cfg_rdata <= APD_RST_BYTE;
    end else begin
      case (i_cfg_index)
        APD_IDX_GLOBAL_STANDBY_COUNT: begin
          o_cfg_rdata <= global_standby_count;
        end
        APD_IDX_POWER_TIMER_SMI_CTRL: begin
          o_cfg_rdata <= APD_RST_BYTE;
          o_cfg_rdata[APD_BIT_TIMER_RES_SEL]  <= timer_resolution_select;
          o_cfg_rdata[APD_BIT_SMI_OUT_EN]     <= smi_output_enable;
          o_cfg_rdata[APD_BIT_SIRQ_PULLUP_EN] <= serial_irq_pullup_enable;
        end
        APD_IDX_TEST_RESERVED: begin
          o_cfg_rdata <= test_reserved;
        end
        APD_IDX_FUNCTION_IDLE_STATUS: begin
          o_cfg_rdata <= nib(function_idle_status);
        end
        APD_IDX_FUNCTION_WAKE_STATUS: begin
          o_cfg_rdata <= nib(function_wake_status);
        end
        APD_IDX_FUNCTION_IRQ_STATUS: begin
          o_cfg_rdata <= nib(function_irq_status);
        end
        APD_IDX_SMI_SOURCE_ENABLE: begin
          o_cfg_rdata <= nib(smi_source_enable);
        end
        default: begin
          o_cfg_rdata <= APD_RST_BYTE;
        end
      endcase
    end
  end

  // Pin synchronisers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prt_pins_meta <= 5'h00;
      prt_pins_sync <= 5'h00;
      modem_meta    <= APD_RST_BYTE;
      modem_sync    <= APD_RST_BYTE;
    end else begin
      prt_pins_meta <= i_printer_status_pins;
      prt_pins_sync <= prt_pins_meta;
      modem_meta    <= {i_uart_a_modem_pins, i_uart_b_modem_pins};
      modem_sync    <= modem_meta;
    end
  end

  // Previous values for change detection
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prt_pins_prev <= 5'h00;
      modem_prev    <= APD_RST_BYTE;
      motor_prev    <= APD_RST_NIB;
    end else begin
      prt_pins_prev <= prt_pins_sync;
      modem_prev    <= modem_sync;
      motor_prev    <= i_drive_output_register_motor;
    end
  end

  assign prt_pin_change  = |(prt_pins_sync ^ prt_pins_prev);
  assign modem_change[1] = |(modem_sync[7:4] ^ modem_prev[7:4]);
  assign modem_change[0] = |(modem_sync[3:0] ^ modem_prev[3:0]);
  assign motor_rise      = |(i_drive_output_register_motor & ~motor_prev);

  // Wake events per function
  always_comb begin
    wake_event[APD_FN_PRINTER] = i_func_access[APD_FN_PRINTER]
      | i_func_irq[APD_FN_PRINTER] | i_printer_dma_ack
      | prt_pin_change;
    wake_event[APD_FN_FLOPPY] = i_func_access[APD_FN_FLOPPY]
      | i_func_irq[APD_FN_FLOPPY] | i_floppy_dma_ack
      | motor_rise;
    wake_event[APD_FN_UART_A] = i_func_access[APD_FN_UART_A]
      | i_func_irq[APD_FN_UART_A] | i_uart_rx_start[1]
      | i_uart_tx_start[1] | modem_change[1];
    wake_event[APD_FN_UART_B] = i_func_access[APD_FN_UART_B]
      | i_func_irq[APD_FN_UART_B] | i_uart_rx_start[0]
      | i_uart_tx_start[0] | modem_change[0];
  end

  // Idle conditions per function
  always_comb begin
    idle_cond[APD_FN_PRINTER] = ~i_func_access[APD_FN_PRINTER]
      & ~i_func_irq[APD_FN_PRINTER] & ~i_printer_dma_ack
      & ~prt_pin_change;
    idle_cond[APD_FN_FLOPPY] = ~i_func_access[APD_FN_FLOPPY]
      & ~i_func_irq[APD_FN_FLOPPY] & ~i_floppy_dma_ack
      & ~(|i_drive_output_register_motor);
    idle_cond[APD_FN_UART_A] = ~i_func_access[APD_FN_UART_A]
      & ~i_func_irq[APD_FN_UART_A] & i_uart_rx_waiting[1]
      & i_uart_tx_empty[1] & ~modem_change[1];
    idle_cond[APD_FN_UART_B] = ~i_func_access[APD_FN_UART_B]
      & ~i_func_irq[APD_FN_UART_B] & i_uart_rx_waiting[0]
      & i_uart_tx_empty[0] & ~modem_change[0];
  end

  assign init_count[APD_FN_PRINTER] = i_printer_idle_count;
  assign init_count[APD_FN_FLOPPY]  = i_floppy_idle_count;
  assign init_count[APD_FN_UART_A]  = i_uart_a_idle_count;
  assign init_count[APD_FN_UART_B]  = i_uart_b_idle_count;

  // Common tick for every idle timer
  apd_tick_gen #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_tick (
    .i_ref_clk    (i_ref_clk),
    .i_rst        (i_rst),
    .i_res_minute (timer_resolution_select),
    .o_tick       (tick)
  );

  // Per-function power-down machines
  genvar fn;
  generate
    for (fn = 0; fn < APD_NUM_FN; fn++) begin : g_fn
      assign pm_active[fn] = i_func_power_mgmt_enable[fn]
        & i_chip_power_mgmt_enable;
      apd_func_pm u_pm (
        .i_ref_clk    (i_ref_clk),
        .i_rst        (i_rst),
        .i_tick       (tick),
        .i_pm_active  (pm_active[fn]),
        .i_wake       (wake_event[fn]),
        .i_idle       (idle_cond[fn]),
        .i_init_count (init_count[fn]),
        .o_sleep      (fn_sleep[fn]),
        .o_expire     (fn_expire[fn]),
        .o_woke       (fn_woke[fn])
      );
    end
  endgenerate

  assign idle_clear = (i_cfg_wr
    && hit(i_cfg_index, APD_IDX_FUNCTION_IDLE_STATUS))
    ? i_cfg_wdata[3:0] : APD_RST_NIB;
  assign wake_clear = (i_cfg_wr
    && hit(i_cfg_index, APD_IDX_FUNCTION_WAKE_STATUS))
    ? i_cfg_wdata[3:0] : APD_RST_NIB;

  // Idle and wake flags, hardware set wins over host clear
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      function_idle_status <= APD_RST_NIB;
      function_wake_status <= APD_RST_NIB;
    end else begin
      function_idle_status <= (function_idle_status & ~idle_clear
        & ~fn_woke) | fn_expire;
      function_wake_status <= (function_wake_status & ~wake_clear
        & ~fn_expire) | fn_woke;
    end
  end

  // IRQ mirror, not writable
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      function_irq_status <= APD_RST_NIB;
    end else begin
      function_irq_status <= i_func_irq;
    end
  end

  // Chip standby machine
  always_comb begin
    next_chip_state    = chip_state;
    next_standby_count = standby_count;
    case (chip_state)
      APD_CHIP_WORK: begin
        if (i_chip_power_mgmt_enable
            && global_standby_count != APD_RST_BYTE
            && (&fn_sleep) && !(|wake_event)) begin
          next_chip_state    = APD_CHIP_COUNT;
          next_standby_count = global_standby_count;
        end
      end
      APD_CHIP_COUNT: begin
        if (|wake_event || !(&fn_sleep)) begin
          next_chip_state = APD_CHIP_WORK;
        end else if (!i_chip_power_mgmt_enable
                     || global_standby_count == APD_RST_BYTE) begin
          next_chip_state = APD_CHIP_COUNT;
        end else if (tick) begin
          if (standby_count <= 8'h01) begin
            next_standby_count = APD_RST_BYTE;
            next_chip_state    = APD_CHIP_SLEEP;
          end else begin
            next_standby_count = standby_count - 8'h01;
          end
        end
      end
      APD_CHIP_SLEEP: begin
        if (|wake_event || !(&fn_sleep)) begin
          next_chip_state = APD_CHIP_WORK;
        end
      end
      default: begin
        next_chip_state    = APD_CHIP_WORK;
        next_standby_count = APD_RST_BYTE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      chip_state    <= APD_CHIP_WORK;
      standby_count <= APD_RST_BYTE;
    end else begin
      chip_state    <= next_chip_state;
      standby_count <= next_standby_count;
    end
  end

  assign smi_logic = |(smi_source_enable & function_irq_status);

  // Output pins
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_smi_n                    <= 1'b1;
      o_serial_irq_pin_smi       <= 1'b0;
      o_serial_irq_pullup_enable <= 1'b0;
      o_chip_sleep               <= 1'b0;
      o_func_sleep               <= APD_RST_NIB;
    end else begin
      o_smi_n <= ~(smi_logic & smi_output_enable
        & i_chip_power_mgmt_enable);
      o_serial_irq_pin_smi <= smi_logic & smi_output_enable
        & i_chip_power_mgmt_enable & i_serial_irq_mode;
      o_serial_irq_pullup_enable <= serial_irq_pullup_enable
        & i_serial_irq_mode;
      o_chip_sleep <= (next_chip_state == APD_CHIP_SLEEP);
      o_func_sleep <= fn_sleep;
    end
  end

endmodule : apd_ctrl

// ==== sim/apd_ctrl_asserts.sv ====
`timescale 1ns/1ps
module apd_ctrl_asserts (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_chip_power_mgmt_enable,
  input  wire logic [3:0] i_func_access,
  input  wire logic [3:0] i_func_irq,
  input  wire logic       i_serial_irq_mode,
  input  wire logic       o_smi_n,
  input  wire logic       o_serial_irq_pin_smi,
  input  wire logic       o_serial_irq_pullup_enable,
  input  wire logic       o_chip_sleep,
  input  wire logic [3:0] o_func_sleep
);
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  a_smi_irq_quiet:
    assert property ((i_func_irq == 4'h0) [*3] |=> o_smi_n)
    else $error("smi low without irq");
  a_smi_pm_off:
    assert property (!i_chip_power_mgmt_enable [*3]
      |=> o_smi_n && !o_serial_irq_pin_smi)
    else $error("smi with chip pm off");
  a_sirq_mode_off:
    assert property (!i_serial_irq_mode [*3] |=> !o_serial_irq_pin_smi)
    else $error("serial smi outside serial mode");
  a_pullup_mode_off:
    assert property (!i_serial_irq_mode [*3]
      |=> !o_serial_irq_pullup_enable)
    else $error("pullup outside serial mode");
  a_func_pm_off:
    assert property (!i_chip_power_mgmt_enable [*3] |=> o_func_sleep == 4'h0)
    else $error("function asleep with chip pm off");
  a_chip_after_all:
    assert property ($rose(o_chip_sleep) |-> $past(&o_func_sleep))
    else $error("chip asleep before all functions");
  a_access_wakes:
    assert property (o_func_sleep[0] && i_func_access[0]
      |-> ##[1:3] !o_func_sleep[0])
    else $error("access did not wake function");
  a_chip_wakes:
    assert property (o_chip_sleep && i_chip_power_mgmt_enable
      && (i_func_access != 4'h0) |-> ##[1:3] !o_chip_sleep)
    else $error("access did not wake chip");
endmodule : apd_ctrl_asserts

bind apd_ctrl apd_ctrl_asserts i_asserts (.*);

// ==== sim/apd_host_model.sv ====
`timescale 1ns/1ps
module apd_host_model import apd_pkg::*; (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_cfg_rdata,
  output logic      [7:0] o_cfg_index,
  output logic            o_cfg_wr,
  output logic      [7:0] o_cfg_wdata
);
  initial begin
    {o_cfg_index, o_cfg_wr, o_cfg_wdata} = 17'h00000;
  end

  task automatic cfg_write(input logic [7:0] idx, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_cfg_index = idx;
    o_cfg_wdata = (idx == APD_IDX_TEST_RESERVED) ? 8'h00 : d;
    o_cfg_wr    = 1'b1;
    @(negedge i_ref_clk);
    o_cfg_wr    = 1'b0;
    o_cfg_wdata = ~o_cfg_wdata;
  endtask : cfg_write

  task automatic cfg_read(input logic [7:0] idx, output logic [7:0] d);
    @(negedge i_ref_clk);
    o_cfg_index = idx;
    @(negedge i_ref_clk);
    d = i_cfg_rdata;
  endtask : cfg_read
endmodule : apd_host_model

// ==== sim/apd_ctrl_tb.sv ====
`timescale 1ns/1ps
module apd_ctrl_tb import apd_pkg::*; ;
  localparam int         SEC = 4;
  localparam logic [7:0] GSB = APD_IDX_GLOBAL_STANDBY_COUNT;
  localparam logic [7:0] CTL = APD_IDX_POWER_TIMER_SMI_CTRL;
  localparam logic [7:0] IDL = APD_IDX_FUNCTION_IDLE_STATUS;
  localparam logic [7:0] WAK = APD_IDX_FUNCTION_WAKE_STATUS;
  localparam logic [7:0] IRQ = APD_IDX_FUNCTION_IRQ_STATUS;
  localparam logic [7:0] SRC = APD_IDX_SMI_SOURCE_ENABLE;
  localparam int         FN [8] = '{3, 3, 2, 2, 1, 0, 1, 0};
  typedef struct {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } apd_row_t;
  apd_row_t rows [10] = '{
    '{GSB, 8'h5a, 8'h5a}, '{CTL, 8'hff, 8'h25},
    '{APD_IDX_TEST_RESERVED, 8'h00, 8'h00}, '{IDL, 8'hff, 8'h00},
    '{WAK, 8'hff, 8'h00}, '{IRQ, 8'hff, 8'h00},
    '{APD_IDX_RESERVED_A, 8'hff, 8'h00},
    '{APD_IDX_RESERVED_B, 8'hff, 8'h00},
    '{SRC, 8'hff, 8'h0f}, '{8'h50, 8'hff, 8'h00}
  };

  logic       i_ref_clk, i_rst, i_cfg_wr, i_chip_power_mgmt_enable;
  logic       i_printer_dma_ack, i_floppy_dma_ack, i_serial_irq_mode;
  logic       o_smi_n, o_serial_irq_pin_smi, o_serial_irq_pullup_enable;
  logic       o_chip_sleep;
  logic [1:0] i_uart_rx_waiting, i_uart_tx_empty;
  logic [1:0] i_uart_rx_start, i_uart_tx_start;
  logic [3:0] i_func_power_mgmt_enable, i_func_access, i_func_irq;
  logic [3:0] o_func_sleep, i_drive_output_register_motor;
  logic [3:0] i_uart_a_modem_pins, i_uart_b_modem_pins;
  logic [4:0] i_printer_status_pins;
  logic [7:0] i_cfg_index, i_cfg_wdata, o_cfg_rdata, cnt;
  int         errors = 0;
  int         comparisons = 0;
  int         n;

  apd_ctrl #(.SEC_CYCLES(SEC)) i_dut (
    .*,
    .i_printer_idle_count(cnt),
    .i_floppy_idle_count (cnt),
    .i_uart_a_idle_count (cnt),
    .i_uart_b_idle_count (cnt)
  );
  apd_host_model i_host (
    .i_ref_clk  (i_ref_clk),
    .i_cfg_rdata(o_cfg_rdata),
    .o_cfg_index(i_cfg_index),
    .o_cfg_wr   (i_cfg_wr),
    .o_cfg_wdata(i_cfg_wdata)
  );

  always #20 i_ref_clk = ~i_ref_clk;

  task automatic cyc(input int k);
    repeat (k) @(negedge i_ref_clk);
  endtask : cyc

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    i_host.cfg_read(idx, d);
    check(d, exp);
  endtask : rd_check

  task automatic poke(input int c);
    case (c)
      0: i_printer_dma_ack = ~i_printer_dma_ack;
      1: i_printer_status_pins = ~i_printer_status_pins;
      2: i_floppy_dma_ack = ~i_floppy_dma_ack;
      3: i_drive_output_register_motor = ~i_drive_output_register_motor;
      4: i_uart_rx_start[1] = ~i_uart_rx_start[1];
      5: i_uart_tx_start[0] = ~i_uart_tx_start[0];
      6: i_uart_a_modem_pins = ~i_uart_a_modem_pins;
      default: i_uart_b_modem_pins = ~i_uart_b_modem_pins;
    endcase
  endtask : poke

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #400000;
    errors++;
    end_of_test();
  end

  initial begin
    i_rst = 1'b1;
    i_ref_clk = 1'b0;
    {i_chip_power_mgmt_enable, i_printer_dma_ack, i_floppy_dma_ack} = 3'h0;
    {i_serial_irq_mode, i_uart_rx_start, i_uart_tx_start} = 5'h00;
    {i_func_access, i_func_irq, i_drive_output_register_motor} = 12'h000;
    {i_uart_a_modem_pins, i_uart_b_modem_pins} = 8'h00;
    i_printer_status_pins = 5'h00;
    {i_uart_rx_waiting, i_uart_tx_empty, i_func_power_mgmt_enable} = 8'hff;
    cnt = 8'h02;
    cyc(6);
    check({o_smi_n, o_chip_sleep, o_func_sleep, o_cfg_rdata[1:0]}, 8'h80);
    i_rst = 1'b0;
    foreach (rows[r]) rd_check(rows[r].idx, 8'h00);
    foreach (rows[r]) begin
      i_host.cfg_write(rows[r].idx, rows[r].wd);
      rd_check(rows[r].idx, rows[r].exp);
    end
    // Interrupt mirror and SMI gating
    i_func_irq = 4'h8;
    cyc(1);
    i_func_irq = 4'h0;
    rd_check(IRQ, 8'h00);
    i_func_irq = 4'h4;
    cyc(3);
    check(8'(o_smi_n), 8'h01);
    rd_check(IRQ, 8'h04);
    i_chip_power_mgmt_enable = 1'b1;
    cyc(3);
    check(8'({o_smi_n, o_serial_irq_pin_smi, o_serial_irq_pullup_enable}),
          8'h00);
    i_serial_irq_mode = 1'b1;
    cyc(3);
    check(8'({o_smi_n, o_serial_irq_pin_smi, o_serial_irq_pullup_enable}),
          8'h03);
    i_host.cfg_write(SRC, 8'h0b);
    cyc(3);
    check(8'(o_smi_n), 8'h01);
    i_host.cfg_write(CTL, 8'h20);
    i_func_irq = 4'h1;
    cyc(3);
    check(8'({o_smi_n, o_serial_irq_pin_smi, o_serial_irq_pullup_enable}),
          8'h04);
    rd_check(IRQ, 8'h01);
    i_func_irq = 4'h0;
    i_serial_irq_mode = 1'b0;
    // Minute resolution, then seconds for the chip countdown
    i_host.cfg_write(GSB, 8'h02);
    cyc(200);
    check({4'h0, o_func_sleep}, 8'h00);
    for (n = 0; n < 600 && o_func_sleep != 4'hf; n++) cyc(1);
    check(8'({o_chip_sleep, o_func_sleep}), 8'h0f);
    i_host.cfg_write(CTL, 8'h00);
    for (n = 0; n < 60 && !o_chip_sleep; n++) cyc(1);
    check(8'(o_chip_sleep), 8'h01);
    rd_check(IDL, 8'h0f);
    // Wake by access, flag clearing
    i_func_access = 4'h8;
    cyc(3);
    check(8'({o_chip_sleep, o_func_sleep}), 8'h07);
    rd_check(WAK, 8'h08);
    rd_check(IDL, 8'h07);
    i_host.cfg_write(WAK, 8'h00);
    rd_check(WAK, 8'h08);
    i_host.cfg_write(WAK, 8'h08);
    rd_check(WAK, 8'h00);
    i_host.cfg_write(IDL, 8'h01);
    rd_check(IDL, 8'h06);
    i_func_access = 4'h0;
    // DMA ack, status pin, motor, start bit and modem wake causes
    for (int c = 0; c < 8; c++) begin
      for (n = 0; n < 60 && !o_func_sleep[FN[c]]; n++) cyc(1);
      poke(c);
      cyc(1);
      poke(c);
      for (n = 0; n < 8 && o_func_sleep[FN[c]]; n++) cyc(1);
      check(8'(o_func_sleep[FN[c]]), 8'h00);
      rd_check(WAK, 8'h01 << FN[c]);
      i_host.cfg_write(WAK, 8'h0f);
    end
    // Busy conditions hold functions awake, UART B by its cleared enable; zero count keeps chip awake
    i_host.cfg_write(GSB, 8'h00);
    i_func_power_mgmt_enable = 4'he;
    {i_printer_dma_ack, i_floppy_dma_ack} = 2'b11;
    i_uart_rx_waiting = 2'b01;
    i_func_access = 4'hf;
    cyc(1);
    i_func_access = 4'h0;
    cyc(40);
    check({4'h0, o_func_sleep}, 8'h00);
    {i_printer_dma_ack, i_floppy_dma_ack} = 2'b00;
    i_uart_rx_waiting = 2'b11;
    i_func_power_mgmt_enable = 4'hf;
    for (n = 0; n < 60 && o_func_sleep != 4'hf; n++) cyc(1);
    cyc(30);
    check(8'({o_chip_sleep, o_func_sleep}), 8'h0f);
    // Reset in mid-run
    i_rst = 1'b1;
    cyc(2);
    check({o_smi_n, o_chip_sleep, o_func_sleep, o_cfg_rdata[1:0]}, 8'h80);
    i_rst = 1'b0;
    rd_check(GSB, 8'h00);
    end_of_test();
  end
endmodule : apd_ctrl_tb
